/* pkg/setws_pkg.sv */
// Shared constants and types for the two-wire serial memory slave.
package setws_pkg;

	// Array geometry.
	localparam int MEM_BYTES = 8192;
	localparam int ADDR_W = 13;
	localparam int PAGE_BYTES = 32;
	localparam int PAGE_W = 5;

	// Device address word layout.
	localparam logic [3:0] DEV_TYPE = 4'ha;
	localparam int TYPE_POS = 4;
	localparam int SEL_POS = 1;
	localparam int RW_POS = 0;

	// Bit counter marks inside one nine-clock word.
	localparam logic [3:0] CNT_ACK = 4'h8;
	localparam logic [3:0] CNT_NEXT = 4'h9;
	localparam logic [3:0] CNT_RST = 4'h0;

	// Values after reset.
	localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// Internal write cycle time and its length in clock cycles.
	localparam int WR_TIME_US = 5000;
	localparam int CLK_MHZ = 125;
	localparam int WR_CYCLES = WR_TIME_US * CLK_MHZ;
	localparam int TMR_W = 20;

	// Number of pin inputs that pass the synchroniser.
	localparam int SYNC_N = 7;
	// Synchroniser contents after reset: both bus wires at their idle high level.
	localparam logic [SYNC_N-1:0] SYNC_RST = 7'h60;

	// Transfer phases, one-hot.
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_DEV = 6'h02,
		ST_ADDH = 6'h04,
		ST_ADDL = 6'h08,
		ST_WDATA = 6'h10,
		ST_RDATA = 6'h20
	} setws_state_t;

	// Open-drain data pin drive.
	typedef struct packed {
		logic out;
		logic oe;
	} setws_sda_drv_t;

	// Pin samples after synchronisation.
	typedef struct packed {
		logic scl;
		logic sda;
		logic wp;
		logic [2:0] sel;
		logic bit_cap;
	} setws_pins_t;

endpackage : setws_pkg

/* hw/setws_eeprom_slave.sv */
// Two-wire serial memory slave: protocol engine, page buffer and array.
`timescale 1ns/100ps

module setws_eeprom_slave #(
	parameter int WR_CYCLES = setws_pkg::WR_CYCLES
) (
	// System clock and reset.
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Two-wire bus; the serial clock is the link clock.
	input wire logic i_scl,
	input wire logic i_sda,
	output setws_pkg::setws_sda_drv_t o_sda,
	// Straps and protection.
	input wire logic i_write_inhibit,
	input wire logic [2:0] i_chip_select_straps,
	// Status.
	output logic o_write_busy
);
	import setws_pkg::*;

	if (WR_CYCLES <= PAGE_BYTES || WR_CYCLES >= 2 ** TMR_W) begin : g_chk
		$error("WR_CYCLES must exceed the page size and fit the timer");
	end

	////////////////////////////////////////////////////////////////////////////
	// Link domain and synchronisers.

	// The data bit is captured on the serial clock itself; it then stays put
	// for a whole clock period, so a two-flop crossing is safe.
	logic link_bit_q;
	always_ff @(posedge i_scl) begin
		link_bit_q <= i_sda;
	end

	logic [SYNC_N-1:0] raw_w;
	logic [SYNC_N-1:0] meta_q;
	logic [SYNC_N-1:0] sync_q;
	setws_pins_t pins_s;
	assign raw_w = {i_scl, i_sda, i_write_inhibit, i_chip_select_straps, link_bit_q};
	assign pins_s = sync_q;

	// Two flops per pin; bus wires reset high so no false edge follows reset.
	for (genvar gi = 0; gi < SYNC_N; gi++) begin : g_sync
		always_ff @(posedge i_clk) begin
			if (i_sys_rst) begin
				meta_q[gi] <= SYNC_RST[gi];
				sync_q[gi] <= SYNC_RST[gi];
			end else begin
				meta_q[gi] <= raw_w[gi];
				sync_q[gi] <= meta_q[gi];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus event detection.

	logic scl_p_q;
	logic sda_p_q;
	logic rise_q;
	logic fall_q;
	logic start_w;
	logic stop_w;
	logic bit_s;
	logic wp_s;

	// Edges are acted on one cycle late so the captured bit has settled.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else begin
			scl_p_q <= pins_s.scl;
			sda_p_q <= pins_s.sda;
			rise_q <= pins_s.scl & ~scl_p_q;
			fall_q <= ~pins_s.scl & scl_p_q;
		end
	end

	// Data edges while the clock stays high frame a command.
	assign start_w = scl_p_q & pins_s.scl & sda_p_q & ~pins_s.sda;
	assign stop_w = scl_p_q & pins_s.scl & ~sda_p_q & pins_s.sda;
	assign bit_s = pins_s.bit_cap;
	assign wp_s = pins_s.wp;

	////////////////////////////////////////////////////////////////////////////
	// Decode of the current phase.

	setws_state_t state_q;
	setws_state_t state_d;
	logic [3:0] cnt_q;
	logic [7:0] shreg_q;
	logic [ADDR_W-1:0] addr_q;
	logic [PAGE_BYTES-1:0] pval_q;
	logic busy_q;
	logic [TMR_W-1:0] tmr_q;
	setws_sda_drv_t sda_q;
	logic [7:0] mem [MEM_BYTES];
	logic [7:0] pbuf [PAGE_BYTES];

	logic in_rx;
	logic in_rd;
	logic rx_shift;
	logic byte_done;
	logic rx_end;
	logic tx_load;
	logic tx_bit;
	logic tx_rel;
	logic mack_slot;
	logic dev_match;
	logic dev_rd;
	logic wr_start;
	logic wr_end;
	logic commit_we;
	logic [PAGE_W-1:0] cidx;
	logic [7:0] rd_byte;

	// While busy the engine sees no events at all.
	assign in_rx = ~busy_q & (state_q inside {ST_DEV, ST_ADDH, ST_ADDL, ST_WDATA});
	assign in_rd = ~busy_q & (state_q == ST_RDATA);
	assign rx_shift = rise_q & in_rx & (cnt_q < CNT_ACK);
	assign byte_done = fall_q & in_rx & (cnt_q == CNT_ACK);
	assign rx_end = fall_q & in_rx & (cnt_q == CNT_NEXT);
	assign tx_load = fall_q & in_rd & (cnt_q == CNT_NEXT);
	assign tx_bit = fall_q & in_rd & (cnt_q != CNT_RST) & (cnt_q < CNT_ACK);
	assign tx_rel = fall_q & in_rd & (cnt_q == CNT_ACK);
	assign mack_slot = rise_q & in_rd & (cnt_q == CNT_ACK);

	// Type code and straps must both match.
	assign dev_match = (shreg_q[7:TYPE_POS] == DEV_TYPE) &
		(shreg_q[TYPE_POS-1:SEL_POS] == pins_s.sel);
	assign dev_rd = shreg_q[RW_POS];

	////////////////////////////////////////////////////////////////////////////
	// Phase sequencing.

	always_comb begin
		state_d = state_q;
		if (busy_q) begin
			state_d = ST_IDLE;
		end else if (start_w) begin
			state_d = ST_DEV;
		end else if (stop_w) begin
			state_d = ST_IDLE;
		end else if (byte_done) begin
			unique case (state_q)
				ST_DEV: begin
					state_d = dev_match ? (dev_rd ? ST_RDATA : ST_ADDH) : ST_IDLE;
				end
				ST_ADDH: begin
					state_d = ST_ADDL;
				end
				ST_ADDL: begin
					state_d = ST_WDATA;
				end
				ST_WDATA, ST_IDLE, ST_RDATA: begin
					state_d = state_q;
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end else if (mack_slot & bit_s) begin
			state_d = ST_IDLE;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Bit counter: 0..7 data, 8 ack clock, 9 after the ack.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || (start_w && !busy_q)) begin
			cnt_q <= CNT_RST;
		end else if (rise_q && (in_rx || in_rd) && cnt_q < CNT_ACK) begin
			cnt_q <= cnt_q + 4'h1;
		end else if (byte_done || mack_slot) begin
			cnt_q <= CNT_NEXT;
		end else if (rx_end || tx_load) begin
			cnt_q <= CNT_RST;
		end
	end

	// Shift register, MSB first in both directions.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			shreg_q <= BYTE_RST;
		end else if (rx_shift) begin
			shreg_q <= {shreg_q[6:0], bit_s};
		end else if (tx_load) begin
			shreg_q <= rd_byte;
		end else if (tx_bit) begin
			shreg_q <= {shreg_q[6:0], 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Address counter.

	// The counter survives between commands, so a read with no address
	// continues one past the last byte touched, wrapping within the page after a write.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			addr_q <= ADDR_RST;
		end else if (byte_done && state_q == ST_ADDH) begin
			addr_q[ADDR_W-1:8] <= shreg_q[ADDR_W-9:0];
		end else if (byte_done && state_q == ST_ADDL) begin
			addr_q[7:0] <= shreg_q;
		end else if (byte_done && state_q == ST_WDATA) begin
			addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + 5'h01;
		end else if (mack_slot) begin
			addr_q <= addr_q + 13'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Data pin drive.

	// Only the enable ever moves; the driven level is a constant low, and
	// every change happens on a detected falling clock, a start, a stop or while busy.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst || start_w || stop_w || busy_q) begin
			sda_q.oe <= 1'b0;
		end else if (byte_done) begin
			sda_q.oe <= (state_q != ST_DEV) | dev_match;
		end else if (rx_end || tx_rel) begin
			sda_q.oe <= 1'b0;
		end else if (tx_load) begin
			sda_q.oe <= ~rd_byte[7];
		end else if (tx_bit) begin
			sda_q.oe <= ~shreg_q[6];
		end
	end

	always_ff @(posedge i_clk) begin
		sda_q.out <= 1'b0;
	end

	assign o_sda = sda_q;

	////////////////////////////////////////////////////////////////////////////
	// Page buffer and timed write cycle.

	// Bytes land in a page buffer and reach the array only after a clean
	// stop; an aborted sequence or a dummy address write programs nothing.
	always_ff @(posedge i_clk) begin
		if (byte_done && state_q == ST_WDATA) begin
			pbuf[addr_q[PAGE_W-1:0]] <= shreg_q;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || wr_end || (byte_done && state_q == ST_DEV)) begin
			pval_q <= '0;
		end else if (byte_done && state_q == ST_WDATA) begin
			pval_q[addr_q[PAGE_W-1:0]] <= 1'b1;
		end
	end

	assign wr_start = stop_w & ~busy_q & (state_q == ST_WDATA) & (|pval_q) & ~wp_s;
	assign wr_end = busy_q & (tmr_q == TMR_W'(WR_CYCLES - 1));
	assign cidx = tmr_q[PAGE_W-1:0];
	assign commit_we = busy_q & (tmr_q < TMR_W'(PAGE_BYTES)) & pval_q[cidx];

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || wr_end) begin
			busy_q <= 1'b0;
		end else if (wr_start) begin
			busy_q <= 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || !busy_q) begin
			tmr_q <= '0;
		end else begin
			tmr_q <= tmr_q + TMR_W'(1);
		end
	end

	// One page entry is programmed per cycle at the start of the cycle.
	always_ff @(posedge i_clk) begin
		if (commit_we) begin
			mem[{addr_q[ADDR_W-1:PAGE_W], cidx}] <= pbuf[cidx];
		end
	end

	assign rd_byte = mem[addr_q];

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_write_busy <= 1'b0;
		end else begin
			o_write_busy <= busy_q | wr_start;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	a_sda_never_high: assert property (!o_sda.out)
		else $error("data pin driven high");
	a_ack_on_match: assert property (byte_done && state_q == ST_DEV && dev_match
		|=> o_sda.oe && state_q != ST_IDLE) else $error("matched address not acked");
	a_nack_mismatch: assert property (byte_done && state_q == ST_DEV && !dev_match
		|=> !o_sda.oe && state_q == ST_IDLE) else $error("mismatch acked");
	a_busy_silent: assert property (busy_q |=> !o_sda.oe && state_q == ST_IDLE)
		else $error("busy device answered");
	a_wp_blocks_write: assert property (stop_w && wp_s && !busy_q |=> !busy_q [*3])
		else $error("write started while inhibited");
	a_page_wrap_step: assert property (byte_done && state_q == ST_WDATA
		|=> addr_q[ADDR_W-1:PAGE_W] == $past(addr_q[ADDR_W-1:PAGE_W])
		&& addr_q[PAGE_W-1:0] == 5'($past(addr_q[PAGE_W-1:0]) + 5'h01))
		else $error("write address left its page");
	a_read_step: assert property (mack_slot |=> addr_q == 13'($past(addr_q) + 13'h0001))
		else $error("read address did not step");
	a_stop_standby: assert property (stop_w && !busy_q && !wr_start |=> state_q == ST_IDLE)
		else $error("stop did not return to standby");
	a_drive_on_fall: assert property ($changed(o_sda.oe) |-> $past(fall_q || start_w
		|| stop_w || busy_q)) else $error("pin changed off a falling clock");
	a_nack_release: assert property (mack_slot && bit_s |=> state_q == ST_IDLE
		##1 !o_sda.oe) else $error("no-ack did not release");
	a_write_starts: assert property (wr_start |=> busy_q ##1 o_write_busy)
		else $error("write cycle not started");
	a_busy_bounded: assert property (busy_q |-> tmr_q < TMR_W'(WR_CYCLES))
		else $error("write cycle overran");

	c_write_ack: cover property (byte_done && state_q == ST_WDATA);
	c_read_byte: cover property (tx_load);
	c_write_cycle: cover property (wr_start);
	c_read_nack: cover property (mack_slot && bit_s);

endmodule : setws_eeprom_slave

/* tb/setws_bus_master.sv */
// Behavioural two-wire bus master that drives the serial clock and pulls the data wire.
`timescale 1ns/100ps

module setws_bus_master #(
	parameter int HALF_NS = 80
) (
	// Resolved level of the data wire.
	input wire logic i_sda,
	// Master drive of the bus.
	output logic o_scl,
	output logic o_sda_low
);
	localparam int Q = HALF_NS / 2;

	////////////////////////////////////////////////////////////////////////////////
	// The clock idles high and stands still between frames.
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	// Start also serves as a repeated start, so data is released while the clock is low.
	task start;
		o_sda_low = 1'b0;
		#Q;
		o_scl = 1'b1;
		#HALF_NS;
		o_sda_low = 1'b1;
		#HALF_NS;
		o_scl = 1'b0;
		#Q;
	endtask : start

	// Stop leaves both lines high, which is the idle bus.
	task stop;
		o_sda_low = 1'b1;
		#Q;
		o_scl = 1'b1;
		#HALF_NS;
		o_sda_low = 1'b0;
		#HALF_NS;
	endtask : stop

	// Data only changes in the middle of the low phase.
	task put_bit(input logic b);
		o_sda_low = ~b;
		#Q;
		o_scl = 1'b1;
		#HALF_NS;
		o_scl = 1'b0;
		#Q;
	endtask : put_bit

	// Sampled mid-high so the device has long settled its drive.
	task get_bit(output logic b);
		o_sda_low = 1'b0;
		#Q;
		o_scl = 1'b1;
		#Q;
		b = i_sda;
		#Q;
		o_scl = 1'b0;
		#Q;
	endtask : get_bit

	// Sends a word MSB first and returns whether it was acknowledged.
	task tx_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i]);
		end
		get_bit(b);
		ack = ~b;
	endtask : tx_byte

	// Reads a word and answers with an acknowledge or, at the end, a no-acknowledge.
	task rx_byte(input logic mack, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			get_bit(d[i]);
		end
		put_bit(~mack);
	endtask : rx_byte

endmodule : setws_bus_master

/* tb/setws_eeprom_slave_tb.sv */
// Self-checking testbench of the two-wire serial memory slave.
`timescale 1ns/100ps

module setws_eeprom_slave_tb;
	import setws_pkg::*;

	localparam int WR_SMALL = 600;
	localparam logic [2:0] STRAPS = 3'h5;
	localparam logic [7:0] DEV_WR = {DEV_TYPE, STRAPS, 1'b0};
	localparam logic [7:0] DEV_RD = {DEV_TYPE, STRAPS, 1'b1};

	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_write_inhibit = 1'b0;
	logic [2:0] i_chip_select_straps = STRAPS;
	logic scl;
	logic m_low;
	logic sda;
	logic busy;
	setws_sda_drv_t drv;
	int errors = 0;
	int checked = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Open-drain wire with a pull-up: low whenever any party pulls.
	assign sda = (drv.oe | m_low) ? 1'b0 : 1'b1;

	setws_eeprom_slave #(.WR_CYCLES(WR_SMALL)) dut (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_scl(scl),
		.i_sda(sda),
		.o_sda(drv),
		.i_write_inhibit(i_write_inhibit),
		.i_chip_select_straps(i_chip_select_straps),
		.o_write_busy(busy)
	);

	setws_bus_master m (
		.i_sda(sda),
		.o_scl(scl),
		.o_sda_low(m_low)
	);

	// System clock of 8 ns.
	initial begin
		forever #4 i_clk = ~i_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task results;
		$display("Comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	// Polling retries the write address, up to ten times, until the write cycle is over.
	task set_addr(input logic [12:0] a);
		logic ack;
		int n;
		n = 0;
		ack = 1'b0;
		while (!ack && n < 10) begin
			m.start();
			m.tx_byte(DEV_WR, ack);
			n++;
		end
		chk("device address ack", 8'h01, {7'h00, ack});
		m.tx_byte({3'h0, a[12:8]}, ack);
		chk("address high ack", 8'h01, {7'h00, ack});
		m.tx_byte(a[7:0], ack);
		chk("address low ack", 8'h01, {7'h00, ack});
	endtask : set_addr

	task wr(input logic [12:0] a, input logic [7:0] d[$]);
		logic ack;
		set_addr(a);
		foreach (d[i]) begin
			m.tx_byte(d[i], ack);
			chk("data ack", 8'h01, {7'h00, ack});
		end
		m.stop();
	endtask : wr

	// Random read, sequential when more than one byte is expected.
	task rd_chk(input logic [12:0] a, input logic [7:0] exp[$]);
		logic ack;
		logic [7:0] d;
		set_addr(a);
		m.start();
		m.tx_byte(DEV_RD, ack);
		chk("read address ack", 8'h01, {7'h00, ack});
		foreach (exp[i]) begin
			m.rx_byte(i < exp.size() - 1, d);
			chk("read data", exp[i], d);
		end
		chk("released after nack", 8'h00, {7'h00, drv.oe});
		chk("drive level", 8'h00, {7'h00, drv.out});
		m.stop();
	endtask : rd_chk

	////////////////////////////////////////////////////////////////////////////////
	task s_byte_write;
		logic ack;
		logic [7:0] d;
		wr(13'h0123, {8'h3c});
		chk("busy after stop", 8'h01, {7'h00, busy});
		m.start();
		m.tx_byte(DEV_WR, ack);
		chk("poll while busy", 8'h00, {7'h00, ack});
		wr(13'h0124, {8'hc3});
		rd_chk(13'h0123, {8'h3c});
		m.start();
		m.tx_byte(DEV_RD, ack);
		m.rx_byte(1'b0, d);
		chk("current address read", 8'hc3, d);
		m.stop();
	endtask : s_byte_write

	// Starts two bytes before a page end and sends 34 bytes, so the page wraps once and the first two bytes sent are overwritten.
	task s_page_wrap;
		logic [7:0] d[$];
		logic [7:0] e[$];
		for (int i = 0; i < 34; i++) begin
			d.push_back(8'h40 + 8'(i));
		end
		for (int i = 0; i < 32; i++) begin
			e.push_back(8'h42 + 8'(i));
		end
		wr(13'h005e, d);
		rd_chk(13'h0040, e);
	endtask : s_page_wrap

	task s_rollover;
		wr(13'h1fff, {8'h5a});
		wr(13'h0000, {8'ha5});
		rd_chk(13'h1fff, {8'h5a, 8'ha5});
	endtask : s_rollover

	// Only the fixed type code with matching straps may be answered.
	task s_addressing;
		logic ack;
		logic [7:0] d;
		for (int k = 0; k < 24; k++) begin
			logic [7:0] dev;
			dev = (k < 16) ? {4'(k), STRAPS, 1'b1} : {DEV_TYPE, 3'(k - 16), 1'b1};
			m.start();
			m.tx_byte(dev, ack);
			if (ack) begin
				m.rx_byte(1'b0, d);
			end
			m.stop();
			chk("address match", {7'h00, dev == DEV_RD}, {7'h00, ack});
		end
	endtask : s_addressing

	task s_inhibit;
		@(negedge i_clk);
		i_write_inhibit = 1'b1;
		wr(13'h0123, {8'h77});
		repeat (20) @(negedge i_clk);
		chk("no write cycle", 8'h00, {7'h00, busy});
		// Reads must still work while programming is blocked.
		rd_chk(13'h0123, {8'h3c});
		i_write_inhibit = 1'b0;
		// With the input low again the same write must land.
		wr(13'h0123, {8'h77});
		rd_chk(13'h0123, {8'h77});
	endtask : s_inhibit

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (5) @(negedge i_clk);
		i_sys_rst = 1'b0;
		repeat (5) @(negedge i_clk);
		s_byte_write();
		s_page_wrap();
		s_rollover();
		s_addressing();
		s_inhibit();
		results();
	end

	// Watchdog sized well above the expected run of some 260 us.
	initial begin
		#700000;
		errors++;
		$display("BAD watchdog expected finish seen hang");
		results();
	end

endmodule : setws_eeprom_slave_tb
